// [common/pmt_link_if.sv]
// serial programming and debug link between programmer and device
// assumes both ends share the system clock domain
`timescale 1ns/1ns
interface pmt_link_if;
  logic serialClock;   // driven by programmer only
  logic devDataOut;
  logic devDataOe;
  logic hostDataOut;
  logic hostDataOe;
  logic serialData;    // resolved wire level

  // pulled high when nobody drives
  assign serialData = devDataOe ? devDataOut :
                      (hostDataOe ? hostDataOut : 1'b1);

  modport device (
    input  serialClock,
    input  serialData,
    output devDataOut,
    output devDataOe
  );
  modport host (
    output serialClock,
    input  serialData,
    output hostDataOut,
    output hostDataOe
  );
endinterface : pmt_link_if

// [common/pmt_pkg.sv]
// types shared by the table-read unit and its programmer end
// assumes nothing beyond the constants header
package pmt_pkg;
  // instruction phases within one cycle
  typedef enum logic [1:0] {
    PMT_PH1,
    PMT_PH2,
    PMT_PH3,
    PMT_PH4
  } pmt_phase_t;

  // serial link command
  typedef enum logic [1:0] {
    PMT_CMD_READ,
    PMT_CMD_WRITE,
    PMT_CMD_NONE0,
    PMT_CMD_NONE1
  } pmt_cmd_t;
endpackage : pmt_pkg

// [common/pmt_regs.svh]
// timing counts and reset values for the program memory table-read unit
// assumes a 20 MHz system clock and a four-phase instruction cycle
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH
`define PMT_RESET_VECTOR   13'h0000
`define PMT_PHASES_PER_CYC 3'h4
`define PMT_TABLE_CYCLES   2'h2
`define PMT_SECTOR0        3'h0
`define PMT_SER_ADDR_BITS  5'h10
`define PMT_SER_DATA_BITS  5'h10
`define PMT_CMD_BITS       2'h2
`endif

// [logic/pmt_programmer.sv]
// programmer end of the serial programming link
// assumes the device end samples data on rising serial clock edges
`timescale 1ns/1ns
`include "pmt_regs.svh"
module pmt_programmer
  import pmt_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  pmt_link_if.host         link,
  input  wire logic        start,
  input  wire logic        writeNotRead,
  input  wire logic [15:0] wordAddr,
  input  wire logic [15:0] wordData,
  output logic             busy,
  output logic             readValid,
  output logic [15:0]      readData
);
  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PMH_IDLE, PMH_CMD, PMH_ADDR, PMH_WDATA, PMH_TURN, PMH_RDATA
  } pmt_hst_state_t;

  pmt_hst_state_t state_reg;
  logic [4:0]     bitCnt_reg;
  logic           phase_reg;      // 0 low half, 1 high half of clock
  logic [15:0]    shift_reg;
  logic           isWrite_reg;
  logic [15:0]    data_reg;

  // serial clock divided by two from the system clock
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_reg <= 1'b0;
      link.serialClock <= 1'b0;
    end else if (state_reg != PMH_IDLE) begin
      phase_reg <= ~phase_reg;
      link.serialClock <= ~phase_reg;
    end else begin
      phase_reg <= 1'b0;
      link.serialClock <= 1'b0;
    end
  end

  // frame state, shift out on falling half, capture on rising half
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg   <= PMH_IDLE;
      bitCnt_reg  <= 5'h00;
      shift_reg   <= 16'h0000;
      isWrite_reg <= 1'b0;
      data_reg    <= 16'h0000;
      link.hostDataOut <= 1'b0;
      link.hostDataOe  <= 1'b0;
      busy        <= 1'b0;
      readValid   <= 1'b0;
      readData    <= 16'h0000;
    end else begin
      readValid <= 1'b0;
      case (state_reg)
        PMH_IDLE: begin
          if (start) begin
            state_reg   <= PMH_CMD;
            isWrite_reg <= writeNotRead;
            data_reg    <= wordData;
            shift_reg   <= wordAddr;
            bitCnt_reg  <= 5'h00;
            busy        <= 1'b1;
            link.hostDataOe  <= 1'b1;
            link.hostDataOut <= writeNotRead;
          end
        end
        PMH_CMD: begin
          if (phase_reg) begin // one command bit
            state_reg  <= PMH_ADDR;
            link.hostDataOut <= shift_reg[15];
          end
        end
        PMH_ADDR: begin
          if (phase_reg) begin
            if (bitCnt_reg == `PMT_SER_ADDR_BITS - 5'h01) begin
              bitCnt_reg <= 5'h00;
              if (isWrite_reg) begin
                state_reg <= PMH_WDATA;
                shift_reg <= data_reg;
                link.hostDataOut <= data_reg[15];
              end else begin
                state_reg <= PMH_TURN;
                link.hostDataOe <= 1'b0; // release for device
              end
            end else begin
              bitCnt_reg <= bitCnt_reg + 5'h01;
              shift_reg  <= {shift_reg[14:0], 1'b0};
              link.hostDataOut <= shift_reg[14];
            end
          end
        end
        PMH_WDATA: begin
          if (phase_reg) begin
            if (bitCnt_reg == `PMT_SER_DATA_BITS - 5'h01) begin
              state_reg <= PMH_IDLE;
              busy      <= 1'b0;
              link.hostDataOe <= 1'b0;
            end else begin
              bitCnt_reg <= bitCnt_reg + 5'h01;
              shift_reg  <= {shift_reg[14:0], 1'b0};
              link.hostDataOut <= shift_reg[14];
            end
          end
        end
        PMH_TURN: begin
          if (phase_reg) state_reg <= PMH_RDATA; // turnaround bit
        end
        PMH_RDATA: begin
          if (phase_reg) begin // sample while clock is high
            shift_reg <= {shift_reg[14:0], link.serialData};
            if (bitCnt_reg == `PMT_SER_DATA_BITS - 5'h01) begin
              state_reg <= PMH_IDLE;
              busy      <= 1'b0;
              readValid <= 1'b1;
              readData  <= {shift_reg[14:0], link.serialData};
            end else begin
              bitCnt_reg <= bitCnt_reg + 5'h01;
            end
          end
        end
        default: state_reg <= PMH_IDLE;
      endcase
    end
  end
endmodule : pmt_programmer

// [logic/pmt_table_read.sv]
// program memory with fetch, table read and serial programming access
// assumes the core drives requests synchronous to clock; the serial
// link pins are synchronous inputs driven by the programmer end
`timescale 1ns/1ns
`include "pmt_regs.svh"
// Summary of operation
// - 16-bit program memory, 4K or 8K words
// - fetch at program counter; table data shared
// - reset starts execution at word zero
// - table address is pointer high and low
// - low byte to destination, high to holding
// - normal read sector zero, extended elsewhere
// - holding register readable and writable by software
// - table instructions take two instruction cycles
// - software avoids overlapping table reads with interrupts
// - programming moves data both ways on one pin
// - nothing else drives programming pins while programming
// - debug uses data pin, clock from tool
// - shared pin functions inert while debugging
// - debug pins still serve programming
// - instruction cycle is four system clock phases
module pmt_table_read
  import pmt_pkg::*;
#(
  parameter int WORDS     = 8192,
  parameter int ADDR_BITS = 13
) (
  input  wire logic                 clock,
  input  wire logic                 srst,
  pmt_link_if.device                link,
  input  wire logic                 debugMode,
  input  wire logic                 pinFuncIn,
  input  wire logic                 pcLoad,
  input  wire logic [ADDR_BITS-1:0] pcLoadValue,
  input  wire logic                 tableReadReq,
  input  wire logic                 extTableReadInstr,
  input  wire logic [2:0]           destSector,
  input  wire logic [7:0]           destAddr,
  input  wire logic [7:0]           tablePtrLow,
  input  wire logic [7:0]           tablePtrHigh,
  input  wire logic                 tableHighWrite,
  input  wire logic [7:0]           tableHighWriteData,
  output logic [ADDR_BITS-1:0]      progCounter,
  output logic [15:0]               instrWord,
  output logic                      instrValid,
  output logic                      tableBusy,
  output logic                      destWrite,
  output logic [7:0]                destWriteAddr,
  output logic [7:0]                destWriteData,
  output logic                      tableReadFault,
  output logic [7:0]                table_high_byte,
  output logic                      pinFuncOut,
  output logic                      progActive
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] progMem [WORDS];

  pmt_phase_t          phase_reg;
  logic                tableSecond_reg;
  logic [ADDR_BITS-1:0] tableAddr_reg;
  logic [7:0]          destAddr_reg;
  logic                tableGo;

  // a table read is accepted only on the first phase of a free cycle
  assign tableGo = tableReadReq && !tableBusy && phase_reg == PMT_PH1
                 && (extTableReadInstr || destSector == `PMT_SECTOR0);

  // ---------------------------------------------------------------
  // instruction phases
  // ---------------------------------------------------------------
  // four phases form one instruction cycle
  always_ff @(posedge clock) begin
    if (srst) phase_reg <= PMT_PH1;
    else case (phase_reg)
      PMT_PH1: phase_reg <= PMT_PH2;
      PMT_PH2: phase_reg <= PMT_PH3;
      PMT_PH3: phase_reg <= PMT_PH4;
      PMT_PH4: phase_reg <= PMT_PH1;
      default: phase_reg <= PMT_PH1;
    endcase
  end

  // program counter and fetch; table read stalls fetch for two cycles
  always_ff @(posedge clock) begin
    if (srst) begin
      progCounter <= `PMT_RESET_VECTOR;
      instrWord   <= 16'h0000;
      instrValid  <= 1'b0;
    end else begin
      instrValid <= 1'b0;
      if (phase_reg == PMT_PH1 && !tableBusy && !tableGo
          && !progActive) begin
        instrWord   <= progMem[progCounter];
        instrValid  <= 1'b1;
        progCounter <= pcLoad ? pcLoadValue
                              : progCounter + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // table read: two instruction cycles, eight clocks
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      tableBusy       <= 1'b0;
      tableSecond_reg <= 1'b0;
      tableAddr_reg   <= '0;
      destAddr_reg    <= 8'h00;
      destWrite       <= 1'b0;
      destWriteAddr   <= 8'h00;
      destWriteData   <= 8'h00;
      tableReadFault  <= 1'b0;
    end else begin
      destWrite      <= 1'b0;
      tableReadFault <= tableReadReq && !tableBusy
                        && phase_reg == PMT_PH1 && !tableGo;
      if (tableGo) begin
        tableBusy     <= 1'b1;
        tableAddr_reg <= ADDR_BITS'({tablePtrHigh, tablePtrLow});
        destAddr_reg  <= destAddr;
      end else if (tableBusy && phase_reg == PMT_PH4) begin
        if (tableSecond_reg) begin
          tableBusy       <= 1'b0;
          tableSecond_reg <= 1'b0;
          destWrite       <= 1'b1;
          destWriteAddr   <= destAddr_reg;
          destWriteData   <= progMem[tableAddr_reg][7:0];
        end else begin
          tableSecond_reg <= 1'b1;
        end
      end
    end
  end

  // holding register: hardware load wins over a software write
  always_ff @(posedge clock) begin
    if (srst) table_high_byte <= 8'h00;
    else if (tableBusy && tableSecond_reg && phase_reg == PMT_PH4)
      table_high_byte <= progMem[tableAddr_reg][15:8];
    else if (tableHighWrite)
      table_high_byte <= tableHighWriteData;
  end
  // pointers are inputs only; nothing here alters them

  // ---------------------------------------------------------------
  // serial programming / debug link
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PMD_IDLE, PMD_CMD, PMD_ADDR, PMD_WDATA, PMD_TURN, PMD_RDATA
  } pmt_lnk_state_t;

  pmt_lnk_state_t       lnkState_reg;
  logic                 clkPrev_reg;
  logic                 isWrite_reg;
  logic [4:0]           bitCnt_reg;
  logic [15:0]          addrShift_reg;
  logic [15:0]          dataShift_reg;
  logic                 rise;
  logic                 fall;

  // clock pin is an input from the tool
  assign rise = link.serialClock && !clkPrev_reg;
  assign fall = !link.serialClock && clkPrev_reg;

  // shared pin function masked while debugging or programming
  always_ff @(posedge clock) begin
    if (srst) pinFuncOut <= 1'b0;
    else pinFuncOut <= (debugMode || progActive) ? 1'b0 : pinFuncIn;
  end

  // same two pins serve programming in either mode
  always_ff @(posedge clock) begin
    if (srst) begin
      lnkState_reg  <= PMD_IDLE;
      clkPrev_reg   <= 1'b0;
      isWrite_reg   <= 1'b0;
      bitCnt_reg    <= 5'h00;
      addrShift_reg <= 16'h0000;
      dataShift_reg <= 16'h0000;
      link.devDataOut <= 1'b0;
      link.devDataOe  <= 1'b0;
      progActive    <= 1'b0;
    end else begin
      clkPrev_reg <= link.serialClock;
      case (lnkState_reg)
        PMD_IDLE: begin
          if (rise) begin
            isWrite_reg  <= link.serialData;
            bitCnt_reg   <= 5'h00;
            progActive   <= 1'b1;
            lnkState_reg <= PMD_ADDR;
          end
        end
        PMD_ADDR: if (rise) begin
          addrShift_reg <= {addrShift_reg[14:0], link.serialData};
          if (bitCnt_reg == `PMT_SER_ADDR_BITS - 5'h01) begin
            bitCnt_reg   <= 5'h00;
            lnkState_reg <= isWrite_reg ? PMD_WDATA : PMD_TURN;
          end else bitCnt_reg <= bitCnt_reg + 5'h01;
        end
        PMD_WDATA: if (rise) begin
          dataShift_reg <= {dataShift_reg[14:0], link.serialData};
          if (bitCnt_reg == `PMT_SER_DATA_BITS - 5'h01) begin
            lnkState_reg <= PMD_IDLE;
            progActive   <= 1'b0;
          end else bitCnt_reg <= bitCnt_reg + 5'h01;
        end
        PMD_TURN: if (fall) begin
          // first fall is the turnaround bit, drive from the second
          if (bitCnt_reg == 5'h00) begin
            bitCnt_reg <= 5'h01;
          end else begin
            bitCnt_reg      <= 5'h00;
            dataShift_reg   <= progMem[addrShift_reg[ADDR_BITS-1:0]];
            link.devDataOe  <= 1'b1;
            link.devDataOut <= progMem[addrShift_reg[ADDR_BITS-1:0]][15];
            lnkState_reg    <= PMD_RDATA;
          end
        end
        PMD_RDATA: if (fall) begin
          if (bitCnt_reg == `PMT_SER_DATA_BITS - 5'h01) begin
            link.devDataOe <= 1'b0;
            lnkState_reg   <= PMD_IDLE;
            progActive     <= 1'b0;
          end else begin
            bitCnt_reg      <= bitCnt_reg + 5'h01;
            dataShift_reg   <= {dataShift_reg[14:0], 1'b0};
            link.devDataOut <= dataShift_reg[14];
          end
        end
        default: lnkState_reg <= PMD_IDLE;
      endcase
    end
  end

  // memory write at the end of a write frame
  always_ff @(posedge clock) begin
    if (lnkState_reg == PMD_WDATA && rise
        && bitCnt_reg == `PMT_SER_DATA_BITS - 5'h01)
      progMem[addrShift_reg[ADDR_BITS-1:0]] <=
        {dataShift_reg[14:0], link.serialData};
  end
endmodule : pmt_table_read

// [verif/pmt_link_checker.sv]
// checker for the serial link joining the programmer and device ends
// assumes it is instantiated beside the link interface, one clock domain
`timescale 1ns/1ns
module pmt_link_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic devDataOut,
  input wire logic devDataOe,
  input wire logic hostDataOut,
  input wire logic hostDataOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // wire ownership and framing
  // ----------------------------------------
  property p_noContention;
    !(devDataOe && hostDataOe);
  endproperty
  a_noContention: assert property (p_noContention)
    else $error("both ends drive the data wire");
  property p_quietAfterReset;
    disable iff (1'b0) srst |=> !devDataOe && !hostDataOe && !serialClock;
  endproperty
  a_quietAfterReset: assert property (p_quietAfterReset)
    else $error("link not idle after reset");
  property p_clkHalfRate;
    $rose(serialClock) |=> !serialClock;
  endproperty
  a_clkHalfRate: assert property (p_clkHalfRate)
    else $error("link clock high longer than one cycle");
  property p_devDriveBound;
    $rose(devDataOe) |-> ##[1:48] !devDataOe;
  endproperty
  a_devDriveBound: assert property (p_devDriveBound)
    else $error("device kept driving past read data");
  property p_hostFrameBound;
    $rose(hostDataOe) |-> ##[1:100] !hostDataOe;
  endproperty
  a_hostFrameBound: assert property (p_hostFrameBound)
    else $error("programmer frame too long");
  property p_turnaround;
    $rose(devDataOe) |-> !$past(hostDataOe, 2);
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("device drove without a turnaround gap");
  // device moves its bit only in the cycle the link clock rises again
  property p_devDataOnRise;
    devDataOe && !$rose(devDataOe) && $changed(devDataOut)
      |-> $rose(serialClock);
  endproperty
  a_devDataOnRise: assert property (p_devDataOnRise)
    else $error("device changed read bit away from clock rise");
  // programmer moves its bit only as the link clock falls
  property p_hostDataOnFall;
    hostDataOe && !$rose(hostDataOe) && $changed(hostDataOut)
      |-> $fell(serialClock);
  endproperty
  a_hostDataOnFall: assert property (p_hostDataOnFall)
    else $error("programmer changed bit away from clock fall");
endmodule : pmt_link_checker

// [verif/tb_program_memory_table_read.sv]
// self-checking bench: programmer and device ends joined by the link
// assumes a 20 MHz clock, memory filled through the serial link
`timescale 1ns/1ns
module tb_program_memory_table_read;
  logic        clock, srst, debugMode, pinFuncIn, pcLoad, start;
  logic        tableReadReq, extTableReadInstr, tableHighWrite;
  logic        instrValid, tableBusy, destWrite, tableReadFault;
  logic        pinFuncOut, progActive, writeNotRead, busy, readValid;
  logic [2:0]  destSector;
  logic [7:0]  destAddr, tablePtrLow, tablePtrHigh, tableHighWriteData;
  logic [7:0]  destWriteAddr, destWriteData, table_high_byte;
  logic [12:0] pcLoadValue, progCounter;
  logic [15:0] instrWord, wordAddr, wordData, readData, rdGot;
  int          failures, tests_run, n;

  pmt_link_if link ();
  pmt_table_read i_pmt_table_read (
    .clock(clock), .srst(srst), .link(link), .debugMode(debugMode),
    .pinFuncIn(pinFuncIn), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .tableReadReq(tableReadReq), .extTableReadInstr(extTableReadInstr),
    .destSector(destSector), .destAddr(destAddr),
    .tablePtrLow(tablePtrLow), .tablePtrHigh(tablePtrHigh),
    .tableHighWrite(tableHighWrite),
    .tableHighWriteData(tableHighWriteData), .progCounter(progCounter),
    .instrWord(instrWord), .instrValid(instrValid), .tableBusy(tableBusy),
    .destWrite(destWrite), .destWriteAddr(destWriteAddr),
    .destWriteData(destWriteData), .tableReadFault(tableReadFault),
    .table_high_byte(table_high_byte), .pinFuncOut(pinFuncOut),
    .progActive(progActive));
  pmt_programmer i_pmt_programmer (
    .clock(clock), .srst(srst), .link(link), .start(start),
    .writeNotRead(writeNotRead), .wordAddr(wordAddr), .wordData(wordData),
    .busy(busy), .readValid(readValid), .readData(readData));
  pmt_link_checker i_pmt_link_checker (
    .clock(clock), .srst(srst), .serialClock(link.serialClock),
    .serialData(link.serialData), .devDataOut(link.devDataOut),
    .devDataOe(link.devDataOe), .hostDataOut(link.hostDataOut),
    .hostDataOe(link.hostDataOe));

  // ----------------------------------------
  // compare, verdict and timeout
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic hang(string what);
    failures++;
    $display("[ERR] %s expected done seen timeout", what);
    stop_test();
  endtask : hang

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // one serial frame; read data lands in rdGot
  task automatic progAccess(logic wr, logic [15:0] a, logic [15:0] d);
    @(negedge clock);
    {start, writeNotRead, wordAddr, wordData} = {1'b1, wr, a, d};
    rdGot = 16'hXXXX;
    @(negedge clock);
    start = 1'b0;
    repeat (2) @(negedge clock);
    chk("progOn", {15'h0, progActive}, 16'h1);
    for (n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(negedge clock);
      if (readValid === 1'b1) rdGot = readData;
    end
    if (n == 200) hang("frame");
    @(negedge clock);
    if (readValid === 1'b1) rdGot = readData;
    chk("progOff", {15'h0, progActive}, 16'h0);
  endtask : progAccess
  // waits for the next fetch pulse, n holds the clocks taken
  task automatic waitFetch;
    @(negedge clock);
    for (n = 1; n < 9 && instrValid !== 1'b1; n++) @(negedge clock);
    if (n == 9) hang("fetch");
  endtask : waitFetch
  // table read; a refused one must pulse the fault and write nothing
  task automatic tableRead(logic ext, logic [2:0] sec, logic [7:0] hi,
                           logic [7:0] lo, logic flt, logic [15:0] exp);
    @(negedge clock);
    {extTableReadInstr, destSector, tablePtrHigh, tablePtrLow} =
      {ext, sec, hi, lo};
    destAddr = {5'h15, sec};
    tableReadReq = 1'b1;
    for (n = 0; n < 8 && tableBusy !== 1'b1 && tableReadFault !== 1'b1; n++)
      @(negedge clock);
    tableReadReq = 1'b0;
    if (n == 8) hang("take");
    if (flt) begin
      chk("fault", {15'h0, tableReadFault}, 16'h1);
      repeat (10) begin
        @(negedge clock);
        chk("noWrite", {15'h0, destWrite | tableBusy}, 16'h0);
      end
    end else begin
      for (n = 1; n < 12 && destWrite !== 1'b1; n++) @(negedge clock);
      chk("cycles", n[15:0], 16'h8);
      chk("busyEnd", {15'h0, tableBusy}, 16'h0);
      chk("low", {8'h0, destWriteData}, {8'h0, exp[7:0]});
      chk("dest", {8'h0, destWriteAddr}, {8'h0, destAddr});
      chk("high", {8'h0, table_high_byte}, {8'h0, exp[15:8]});
    end
  endtask : tableRead

  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    {srst, debugMode, pinFuncIn, pcLoad, pcLoadValue, start} = {4'h8, 14'h0};
    {tableReadReq, extTableReadInstr, tableHighWrite, destSector} = 6'h0;
    {destAddr, tablePtrLow, tablePtrHigh, tableHighWriteData} = 32'h0;
    {writeNotRead, wordAddr, wordData, failures, tests_run} = '0;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    progAccess(1'b1, 16'h0000, 16'h1234);
    progAccess(1'b1, 16'h1F06, 16'hAB1A);
    progAccess(1'b1, 16'h1F05, 16'h0F0F);
    progAccess(1'b0, 16'h1F06, 16'h0000);
    chk("readback", rdGot, 16'hAB1A);
    tableRead(1'b0, 3'h0, 8'h1F, 8'h06, 1'b0, 16'hAB1A);
    tableRead(1'b0, 3'h0, 8'hFF, 8'h05, 1'b0, 16'h0F0F);
    tableRead(1'b0, 3'h3, 8'h1F, 8'h06, 1'b1, 16'h0000);
    tableRead(1'b1, 3'h5, 8'h1F, 8'h06, 1'b0, 16'hAB1A);
    // software write of the holding register
    @(negedge clock);
    {tableHighWrite, tableHighWriteData} = 9'h15A;
    @(negedge clock);
    tableHighWrite = 1'b0;
    chk("tblHigh", {8'h0, table_high_byte}, 16'h005A);
    // fetch spacing and program counter load
    waitFetch();
    waitFetch();
    chk("fetchGap", n[15:0], 16'h4);
    {pcLoad, pcLoadValue} = 14'h3F06;
    waitFetch();
    pcLoad = 1'b0;
    chk("pcLoad", {3'h0, progCounter}, 16'h1F06);
    waitFetch();
    chk("fetchWord", instrWord, 16'hAB1A);
    // shared pin function, masked in debug, link still usable
    pinFuncIn = 1'b1;
    repeat (2) @(negedge clock);
    chk("pinFunc", {15'h0, pinFuncOut}, 16'h1);
    debugMode = 1'b1;
    @(negedge clock);
    chk("pinMask", {15'h0, pinFuncOut}, 16'h0);
    progAccess(1'b0, 16'h0000, 16'h0000);
    chk("dbgRead", rdGot, 16'h1234);
    debugMode = 1'b0;
    // second reset restarts at the reset vector
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    chk("vecValid", {15'h0, instrValid}, 16'h1);
    chk("vecPc", {3'h0, progCounter}, 16'h0001);
    chk("vecWord", instrWord, 16'h1234);
    stop_test();
  end
endmodule : tb_program_memory_table_read
